// ### cpt_pkg.sv
// Behaviour
// - low_source_select 0 feeds slow oscillator, 1 feeds fast oscillator to prescaler.
// - ratio code 11 divides by 256, 10 by 32, 01 by 4, 00 by 1.
// - event mode ignores source select and ratio; external edges clock the counter.
// - run_bit 1 runs prescaler, counter decrements per divided clock; 0 stops it.
// - every 16-bit underflow sets underflow_flag and, with underflow_mask 1, raises the interrupt request.
// - underflow_mask gates only the request; the flag is always set.
// - toggle_output flips on each selected underflow, half the underflow rate.
// - output_enable 1 drives toggle onto output_pin; 0 holds the pin high.
// - pin gating follows output_enable directly; short pulses may appear, no resync.
// - while running, half-rate underflow toggle goes to serial interface regardless of enable.
// - reset leaves the fast oscillator switched off.
// - mode register holds chain, event, noise reject, edge polarity; all reset 0.
// - output_channel_select 1 picks high underflow, 0 low byte underflow; resets 0.
// - second register holds channel, output enable, both source selects; resets 0.
// - low byte borrow decrements the high byte in 16-bit mode.
// - on underflow the counter reloads from reload registers and keeps counting.
// - writing 1 to reload_strobe loads reload value; run_bit keeps the count.
// - reading low count nibble latches upper bits; software reads low first.
package cpt_pkg;

    // register addresses
    localparam logic [15:0] ADDR_MODE      = 16'hffc0;
    localparam logic [15:0] ADDR_OUTSRC    = 16'hffc1;
    localparam logic [15:0] ADDR_PRESC     = 16'hffc2;
    localparam logic [15:0] ADDR_RELOAD0   = 16'hffc4;
    localparam logic [15:0] ADDR_RELOAD1   = 16'hffc5;
    localparam logic [15:0] ADDR_RELOAD2   = 16'hffc6;
    localparam logic [15:0] ADDR_RELOAD3   = 16'hffc7;
    localparam logic [15:0] ADDR_DATA0     = 16'hffc8;
    localparam logic [15:0] ADDR_DATA1     = 16'hffc9;
    localparam logic [15:0] ADDR_DATA2     = 16'hffca;
    localparam logic [15:0] ADDR_DATA3     = 16'hffcb;
    localparam logic [15:0] ADDR_FLAG      = 16'hffe0;
    localparam logic [15:0] ADDR_MASK      = 16'hffe1;
    localparam logic [15:0] ADDR_OSC       = 16'hffe2;

    // mode register fields
    localparam int BIT_CHAIN    = 3;
    localparam int BIT_EVENT    = 2;
    localparam int BIT_NOISE    = 1;
    localparam int BIT_POLARITY = 0;
    // output and source register fields
    localparam int BIT_OUTPUT_CHANNEL_SELECT    = 3;
    localparam int BIT_OUTEN    = 2;
    localparam int BIT_SRC_HI   = 1;
    localparam int BIT_SRC_LO   = 0;
    // prescaler and run register fields
    localparam int BIT_RATIO_HI = 3;
    localparam int BIT_RATIO_LO = 2;
    localparam int BIT_RELOAD   = 1;
    localparam int BIT_RUN      = 0;

    // reset values
    localparam logic [3:0]  RST_NIBBLE = 4'h0;
    localparam logic [15:0] RST_WORD   = 16'h0000;

    // prescaler division ratios (terminal counts are ratio minus one)
    localparam logic [7:0] DIV_1_LAST   = 8'h00;
    localparam logic [7:0] DIV_4_LAST   = 8'h03;
    localparam logic [7:0] DIV_32_LAST  = 8'h1f;
    localparam logic [7:0] DIV_256_LAST = 8'hff;

    // sync stage count for external inputs
    localparam int SYNC_STAGES = 2;
    localparam int NUM_SYNC    = 3;
    localparam int SYNC_SLOW   = 0;
    localparam int SYNC_FAST   = 1;
    localparam int SYNC_EVENT  = 2;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [3:0]  wdata;
        logic        wr;
        logic        rd;
    } cpt_bus_s;

endpackage

// ### cpt_prescaler.sv
`timescale 1ns/100ps
// divides a one-cycle source tick by 1, 4, 32 or 256
module cpt_prescaler
    import cpt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       src_tick,
    input  wire logic       run,
    input  wire logic [1:0] ratio,
    output logic            div_tick
);

    logic [7:0] div_cnt;
    logic [7:0] last;

    // terminal count per ratio code
    always_comb begin
        case (ratio)
            2'b11:   last = DIV_256_LAST;
            2'b10:   last = DIV_32_LAST;
            2'b01:   last = DIV_4_LAST;
            default: last = DIV_1_LAST;
        endcase
    end

    // divider counter; stopped and cleared while not running
    always_ff @(posedge ref_clk) begin
        if (rst || !run) begin
            div_cnt <= 8'h00;
        end else if (src_tick) begin
            if (div_cnt >= last) begin
                div_cnt <= 8'h00;
            end else begin
                div_cnt <= div_cnt + 8'h01;
            end
        end
    end

    // divided tick pulse
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_tick <= 1'b0;
        end else begin
            div_tick <= run && src_tick && (div_cnt >= last);
        end
    end

endmodule // cpt_prescaler

// ### cpt_timer.sv
`timescale 1ns/100ps
// 16-bit chained down-counter with prescaler, underflow flag and toggle output
module cpt_timer
    import cpt_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire cpt_bus_s   bus,
    output logic [3:0]      rd_data,
    input  wire logic       slow_oscillator,
    input  wire logic       fast_oscillator,
    input  wire logic       event_input,
    output logic            fast_osc_enable,
    output logic            output_pin,
    output logic            serial_clk,
    output logic            irq
);

    // register state
    logic        chain_select;
    logic        event_mode_select;
    logic        noise_reject_enable;
    logic        edge_polarity;
    logic        output_channel_select;
    logic        output_enable;
    logic        high_source_select;
    logic        low_source_select;
    logic        ratio_bit_hi;
    logic        ratio_bit_lo;
    logic        run_bit;
    logic [7:0]  reload_low;
    logic [7:0]  reload_high;
    logic        underflow_flag;
    logic        underflow_mask;

    // counter state
    logic [15:0] count;
    logic [11:0] count_hold;
    logic        toggle_output;
    logic        serial_toggle;

    // synchroniser and edge detect state
    logic [NUM_SYNC-1:0] sync_in;
    logic [NUM_SYNC-1:0] sync_out;
    logic [NUM_SYNC-1:0] sync_prev;

    // combinational helpers
    logic        wr_mode;
    logic        wr_outsrc;
    logic        wr_presc;
    logic        reload_req;
    logic        rd_low_data;
    logic        src_tick;
    logic        presc_tick;
    logic        event_tick;
    logic        count_tick;
    logic        low_borrow;
    logic        full_underflow;
    logic        chan_underflow;
    logic [15:0] reload_value;
    logic [3:0]  next_rd_data;

    assign sync_in[SYNC_SLOW]  = slow_oscillator;
    assign sync_in[SYNC_FAST]  = fast_oscillator;
    assign sync_in[SYNC_EVENT] = event_input;

    // two-flop synchroniser per external input, plus a third stage for edges
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SYNC; gi = gi + 1) begin : g_sync
            logic [SYNC_STAGES-1:0] chain;
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    chain          <= '0;
                    sync_prev[gi]  <= 1'b0;
                end else begin
                    chain          <= {chain[SYNC_STAGES-2:0], sync_in[gi]};
                    sync_prev[gi]  <= chain[SYNC_STAGES-1];
                end
            end
            assign sync_out[gi] = chain[SYNC_STAGES-1];
        end
    endgenerate

    // write decodes
    assign wr_mode    = bus.wr && (bus.addr == ADDR_MODE);
    assign wr_outsrc  = bus.wr && (bus.addr == ADDR_OUTSRC);
    assign wr_presc   = bus.wr && (bus.addr == ADDR_PRESC);
    assign reload_req = wr_presc && bus.wdata[BIT_RELOAD];

    // mode register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            chain_select        <= 1'b0;
            event_mode_select   <= 1'b0;
            noise_reject_enable <= 1'b0;
            edge_polarity       <= 1'b0;
        end else if (wr_mode) begin
            chain_select        <= bus.wdata[BIT_CHAIN];
            event_mode_select   <= bus.wdata[BIT_EVENT];
            noise_reject_enable <= bus.wdata[BIT_NOISE];
            edge_polarity       <= bus.wdata[BIT_POLARITY];
        end
    end

    // output and source select register
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            output_channel_select <= 1'b0;
            output_enable         <= 1'b0;
            high_source_select    <= 1'b0;
            low_source_select     <= 1'b0;
        end else if (wr_outsrc) begin
            output_channel_select <= bus.wdata[BIT_OUTPUT_CHANNEL_SELECT];
            output_enable         <= bus.wdata[BIT_OUTEN];
            high_source_select    <= bus.wdata[BIT_SRC_HI];
            low_source_select     <= bus.wdata[BIT_SRC_LO];
        end
    end

    // prescaler ratio and run control
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ratio_bit_hi <= 1'b0;
            ratio_bit_lo <= 1'b0;
            run_bit      <= 1'b0;
        end else if (wr_presc) begin
            ratio_bit_hi <= bus.wdata[BIT_RATIO_HI];
            ratio_bit_lo <= bus.wdata[BIT_RATIO_LO];
            run_bit      <= bus.wdata[BIT_RUN];
        end
    end

    // reload registers, one nibble per address
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            reload_low  <= 8'h00;
            reload_high <= 8'h00;
        end else if (bus.wr) begin
            case (bus.addr)
                ADDR_RELOAD0: reload_low[3:0]  <= bus.wdata;
                ADDR_RELOAD1: reload_low[7:4]  <= bus.wdata;
                ADDR_RELOAD2: reload_high[3:0] <= bus.wdata;
                ADDR_RELOAD3: reload_high[7:4] <= bus.wdata;
                default: ;
            endcase
        end
    end

    // underflow mask
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            underflow_mask <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_MASK) begin
            underflow_mask <= bus.wdata[0];
        end
    end

    // fast oscillator switch, off after reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fast_osc_enable <= 1'b0;
        end else if (bus.wr && bus.addr == ADDR_OSC) begin
            fast_osc_enable <= bus.wdata[0];
        end
    end

    // source edge from the chosen oscillator
    always_comb begin
        if (low_source_select) begin
            src_tick = sync_out[SYNC_FAST] && !sync_prev[SYNC_FAST];
        end else begin
            src_tick = sync_out[SYNC_SLOW] && !sync_prev[SYNC_SLOW];
        end
    end

    cpt_prescaler u_presc (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .src_tick (src_tick),
        .run      (run_bit),
        .ratio    ({ratio_bit_hi, ratio_bit_lo}),
        .div_tick (presc_tick)
    );

    // external event edge, rising when polarity is 1 else falling
    assign event_tick = edge_polarity ? (sync_out[SYNC_EVENT] && !sync_prev[SYNC_EVENT])
                                      : (!sync_out[SYNC_EVENT] && sync_prev[SYNC_EVENT]);

    // count clock; event mode bypasses source and ratio
    assign count_tick = run_bit && (event_mode_select ? event_tick : presc_tick);

    // borrow and underflow detection
    assign low_borrow     = count_tick && (count[7:0] == 8'h00);
    assign full_underflow = count_tick && (count == RST_WORD);
    assign chan_underflow = output_channel_select ? full_underflow : low_borrow;
    assign reload_value   = {reload_high, reload_low};

    // chained down-counter
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= RST_WORD;
        end else if (reload_req) begin
            count <= reload_value;
        end else if (full_underflow) begin
            count <= reload_value;
        end else if (count_tick) begin
            count[7:0] <= count[7:0] - 8'h01;
            if (low_borrow) begin
                count[15:8] <= count[15:8] - 8'h01;
            end
        end
    end

    // underflow flag; set wins over a write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            underflow_flag <= 1'b0;
        end else if (full_underflow) begin
            underflow_flag <= 1'b1;
        end else if (bus.wr && bus.addr == ADDR_FLAG && bus.wdata[0]) begin
            underflow_flag <= 1'b0;
        end
    end

    // interrupt request, mask gates only the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= (underflow_flag || full_underflow) && underflow_mask;
        end
    end

    // pin toggle on selected underflow
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            toggle_output <= 1'b0;
        end else if (chan_underflow) begin
            toggle_output <= !toggle_output;
        end
    end

    // serial clock toggle on full underflow while running
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            serial_toggle <= 1'b0;
        end else if (full_underflow) begin
            serial_toggle <= !serial_toggle;
        end
    end

    assign serial_clk = serial_toggle;

    // pin gating, ungated by any resync so a short pulse may appear
    assign output_pin = output_enable ? toggle_output : 1'b1;

    // upper count bits held when the low nibble is read
    assign rd_low_data = bus.rd && (bus.addr == ADDR_DATA0);
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count_hold <= 12'h000;
        end else if (rd_low_data) begin
            count_hold <= count[15:4];
        end
    end

    // read mux
    always_comb begin
        next_rd_data = RST_NIBBLE;
        case (bus.addr)
            ADDR_MODE:    next_rd_data = {chain_select, event_mode_select,
                                          noise_reject_enable, edge_polarity};
            ADDR_OUTSRC:  next_rd_data = {output_channel_select, output_enable,
                                          high_source_select, low_source_select};
            ADDR_PRESC:   next_rd_data = {ratio_bit_hi, ratio_bit_lo, 1'b0, run_bit};
            ADDR_RELOAD0: next_rd_data = reload_low[3:0];
            ADDR_RELOAD1: next_rd_data = reload_low[7:4];
            ADDR_RELOAD2: next_rd_data = reload_high[3:0];
            ADDR_RELOAD3: next_rd_data = reload_high[7:4];
            ADDR_DATA0:   next_rd_data = count[3:0];
            ADDR_DATA1:   next_rd_data = count_hold[3:0];
            ADDR_DATA2:   next_rd_data = count_hold[7:4];
            ADDR_DATA3:   next_rd_data = count_hold[11:8];
            ADDR_FLAG:    next_rd_data = {3'b000, underflow_flag};
            ADDR_MASK:    next_rd_data = {3'b000, underflow_mask};
            ADDR_OSC:     next_rd_data = {3'b000, fast_osc_enable};
            default:      next_rd_data = RST_NIBBLE;
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rd_data <= RST_NIBBLE;
        end else if (bus.rd) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= RST_NIBBLE;
        end
    end

endmodule // cpt_timer

// ### cpt_checker.sv
`timescale 1ns/100ps
// watches the timer ports: bus, pin, serial clock and request
module cpt_checker
    import cpt_pkg::*;
(
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire cpt_bus_s   bus,
    input wire logic [3:0] rd_data,
    input wire logic       slow_oscillator,
    input wire logic       fast_oscillator,
    input wire logic       event_input,
    input wire logic       fast_osc_enable,
    input wire logic       output_pin,
    input wire logic       serial_clk,
    input wire logic       irq
);
    logic       mask_q;
    logic       outen_q;
    logic       output_channel_select_q;
    logic       run_q;
    logic [3:0] stop_cnt;

    // shadow copies of the control bits software wrote
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            mask_q  <= 1'b0;
            outen_q <= 1'b0;
            output_channel_select_q <= 1'b0;
            run_q   <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == ADDR_MASK) mask_q <= bus.wdata[0];
            if (bus.addr == ADDR_PRESC) run_q <= bus.wdata[BIT_RUN];
            if (bus.addr == ADDR_OUTSRC) begin
                outen_q <= bus.wdata[BIT_OUTEN];
                output_channel_select_q <= bus.wdata[BIT_OUTPUT_CHANNEL_SELECT];
            end
        end
    end

    // cycles since the run bit went low, saturating
    always_ff @(posedge ref_clk) begin
        if (rst || run_q) stop_cnt <= 4'h0;
        else if (stop_cnt != 4'hf) stop_cnt <= stop_cnt + 4'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_underflow;
        $changed(serial_clk);
    endsequence
    sequence s_osc_write;
        bus.wr && bus.addr == ADDR_OSC;
    endsequence

    chk_reset_outs: assert property ($fell(rst) |-> !fast_osc_enable && !irq && !serial_clk && output_pin)
        else $error("outputs not at reset level");
    chk_read_idle: assert property (!$past(bus.rd) |-> rd_data == 4'h0)
        else $error("read data outside read cycle");
    chk_osc_write: assert property (s_osc_write |=> fast_osc_enable == $past(bus.wdata[0]))
        else $error("oscillator enable not updated");
    chk_irq_raise: assert property (s_underflow ##0 (mask_q && $past(mask_q)) |-> ##[0:1] irq)
        else $error("underflow did not raise request");
    chk_irq_masked: assert property (!mask_q && !$past(mask_q) |-> !irq)
        else $error("masked request seen");
    chk_pin_high: assert property (!outen_q && !$past(outen_q) |-> output_pin)
        else $error("disabled pin not high");
    chk_pin_follow: assert property (outen_q && output_channel_select_q && $past(outen_q) && $past(output_channel_select_q)
        && $changed(output_pin) |-> $changed(serial_clk))
        else $error("pin moved without underflow");
    chk_run_stop: assert property (stop_cnt >= 4'h4 |-> $stable(serial_clk))
        else $error("serial clock moves while stopped");
    chk_serial_gap: assert property (s_underflow |=> $stable(serial_clk))
        else $error("serial clock toggled twice in a row");
endmodule // cpt_checker

bind cpt_timer cpt_checker u_chk (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
    .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator), .event_input(event_input),
    .fast_osc_enable(fast_osc_enable), .output_pin(output_pin), .serial_clk(serial_clk), .irq(irq));

// ### cpt_osc_model.sv
`timescale 1ns/100ps
// slow and fast oscillators; the fast one only runs once enabled and settled
module cpt_osc_model #(
    parameter realtime SLOW_HALF = 24.0,
    parameter realtime FAST_HALF = 16.0,
    parameter realtime SETTLE    = 201.0
) (
    input  wire logic fast_osc_enable,
    output logic      slow_oscillator,
    output logic      fast_oscillator
);
    // slow oscillator runs free
    initial begin
        slow_oscillator = 1'b0;
        forever #SLOW_HALF slow_oscillator = ~slow_oscillator;
    end
    // fast oscillator stands low while off, starts after settling
    initial begin
        fast_oscillator = 1'b0;
        forever begin
            wait (fast_osc_enable === 1'b1);
            #SETTLE;
            while (fast_osc_enable === 1'b1) #FAST_HALF fast_oscillator = ~fast_oscillator;
            fast_oscillator = 1'b0;
        end
    end
endmodule // cpt_osc_model

// ### cpt_timer_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module cpt_timer_tb
    import cpt_pkg::*;
;
    logic       ref_clk, rst, event_input, slow_oscillator, fast_oscillator;
    logic       fast_osc_enable, output_pin, serial_clk, irq, pend, ser_q, pin_q;
    cpt_bus_s   bus;
    logic [3:0] rd_data, e_c, r;
    logic [3:0] exp_q[$];
    string      nm_q[$];
    string      nm_c;
    int         n_fail, n_tests, cyc, ser_cnt, pin_cnt, ser_per, ser_at, s, p, k;
    int         divs[4] = '{1, 4, 32, 256};
    logic [15:0] regs[8] = '{ADDR_MODE, ADDR_OUTSRC, ADDR_PRESC, ADDR_FLAG, ADDR_MASK, ADDR_OSC,
                             ADDR_RELOAD0, 16'hffd0};

    cpt_timer u_dut (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
        .slow_oscillator(slow_oscillator), .fast_oscillator(fast_oscillator), .event_input(event_input),
        .fast_osc_enable(fast_osc_enable), .output_pin(output_pin), .serial_clk(serial_clk), .irq(irq));
    cpt_osc_model u_osc (.fast_osc_enable(fast_osc_enable), .slow_oscillator(slow_oscillator),
        .fast_oscillator(fast_oscillator));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        bus.wr <= 1'b0;
    endtask

    // queue the expected nibble, then issue the read
    task automatic rd(input logic [15:0] a, input logic [3:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        @(posedge ref_clk);
        bus <= '{a, 4'h0, 1'b0, 1'b1};
        @(posedge ref_clk);
        bus.rd <= 1'b0;
    endtask

    // load reload value, then reload and run with a ratio code
    task automatic ld(input logic [15:0] v, input logic [1:0] ratio);
        for (int i = 0; i < 4; i++) wr(ADDR_RELOAD0 + 16'(i), v[4*i +: 4]);
        wr(ADDR_PRESC, {ratio, 2'b11});
    endtask

    task automatic wait_ser(input int n, input int lim);
        int b;
        b = ser_cnt;
        for (int i = 0; i < lim && ser_cnt < b + n; i++) @(negedge ref_clk);
        if (ser_cnt < b + n) begin
            n_fail++;
            $display("[FAIL] serial wait exp %0d got %0d", n, ser_cnt - b);
            close_out();
        end
    endtask

    // read data checker and edge counters, sampled mid-cycle
    always @(posedge ref_clk) pend <= bus.rd;
    always @(negedge ref_clk) begin
        cyc++;
        if (pend) begin
            e_c = exp_q.pop_front();
            nm_c = nm_q.pop_front();
            `CHK(nm_c, e_c, rd_data)
        end
        if (serial_clk !== ser_q) begin
            ser_cnt++;
            ser_per = cyc - ser_at;
            ser_at = cyc;
        end
        if (output_pin !== pin_q) pin_cnt++;
        ser_q = serial_clk;
        pin_q = output_pin;
    end

    initial begin
        #800000;
        n_fail++;
        close_out();
    end

    initial begin
        rst = 1'b1;
        bus = '0;
        event_input = 1'b0;
        void'($urandom(62418));
        repeat (10) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(regs[i], 4'h0, "reset_value");
        @(negedge ref_clk);
        `CHK("pin_reset", 1'b1, output_pin)
        `CHK("osc_reset", 1'b0, fast_osc_enable)
        // random read-back of mode and reload nibbles
        for (int i = 0; i < 4; i++) begin
            r = 4'($urandom);
            wr(ADDR_MODE, r);
            rd(ADDR_MODE, r, "mode");
            wr(ADDR_RELOAD0 + 16'(i), ~r);
            rd(ADDR_RELOAD0 + 16'(i), ~r, "reload");
            wr(ADDR_OUTSRC, r);
            rd(ADDR_OUTSRC, r, "outsrc");
        end
        wr(ADDR_MODE, 4'h0);
        wr(ADDR_OUTSRC, 4'h0);
        wr(ADDR_PRESC, 4'b1110);
        rd(ADDR_PRESC, 4'b1100, "presc_strobe");
        // stopped count reads back the reload value, low nibble first
        ld(16'h4321, 2'b00);
        wr(ADDR_PRESC, 4'b0010);
        for (int i = 0; i < 4; i++) rd(ADDR_DATA0 + 16'(i), 4'(i + 1), "count");
        // each ratio code, reload 1 gives two ticks per underflow
        for (k = 0; k < 4; k++) begin
            ld(16'h0001, k[1:0]);
            wait_ser(2, 40 * divs[k]);
            `CHK("period", 1'b1, ser_per >= 12 * divs[k] - 1 && ser_per <= 12 * divs[k] + 1)
        end
        wr(ADDR_PRESC, 4'h0);
        rd(ADDR_FLAG, 4'h1, "flag_set");
        @(negedge ref_clk);
        `CHK("irq_masked", 1'b0, irq)
        wr(ADDR_MASK, 4'h1);
        repeat (2) @(negedge ref_clk);
        `CHK("irq_on", 1'b1, irq)
        wr(ADDR_FLAG, 4'h1);
        rd(ADDR_FLAG, 4'h0, "flag_clear");
        @(negedge ref_clk);
        `CHK("irq_off", 1'b0, irq)
        // fast source stands still until its oscillator is on
        wr(ADDR_OUTSRC, 4'b0001);
        ld(16'h0001, 2'b00);
        s = ser_cnt;
        repeat (100) @(negedge ref_clk);
        `CHK("fast_off", s, ser_cnt)
        wr(ADDR_OSC, 4'h1);
        wait_ser(2, 200);
        `CHK("fast_period", 1'b1, ser_per >= 7 && ser_per <= 9)
        // pin follows 16-bit underflows, then low byte borrows
        wr(ADDR_OUTSRC, 4'b1100);
        ld(16'h0001, 2'b00);
        wait_ser(1, 100);
        s = ser_cnt;
        p = pin_cnt;
        wait_ser(4, 200);
        `CHK("pin_high_chan", ser_cnt - s, pin_cnt - p)
        wr(ADDR_OUTSRC, 4'b0100);
        ld(16'h0200, 2'b00);
        s = ser_cnt;
        p = pin_cnt;
        wait_ser(2, 8000);
        `CHK("pin_low_chan", 1'b1, pin_cnt - p >= 2 * (ser_cnt - s))
        wr(ADDR_OUTSRC, 4'b0000);
        @(negedge ref_clk);
        `CHK("pin_off", 1'b1, output_pin)
        // zero reload underflows on every count clock
        ld(16'h0000, 2'b00);
        wait_ser(2, 60);
        `CHK("zero_reload", 1'b1, ser_per >= 5 && ser_per <= 7)
        // event mode ignores ratio and source, counts chosen edge
        for (k = 0; k < 2; k++) begin
            wr(ADDR_MODE, {3'b110, k[0]});
            ld(16'h0001, 2'b00);
            s = ser_cnt;
            repeat (4) begin
                @(posedge ref_clk) event_input <= 1'b1;
                repeat (5) @(posedge ref_clk);
                event_input <= 1'b0;
                repeat (5) @(posedge ref_clk);
            end
            repeat (8) @(negedge ref_clk);
            `CHK("event_count", s + 2, ser_cnt)
        end
        wr(ADDR_PRESC, 4'h0);
        close_out();
    end
endmodule // cpt_timer_tb
